// ---- hw/aux_irq_defs.svh ----
// Register offsets, field positions and reset values for the aux/irq block
// Operation
// R1: Enabled port-0 pin low sets keypad flag
// R2: Brownout off bit disables detection
// R3: Irq mode picks interrupt instead of reset
// R4: Sleep-only bit powers detector in power-down
// R5: Power-down with detection starts RC oscillator
// R6: Soft reset bit resets whole chip
// R7: Bank select routes pointer operations
// R8: Global gate blocks every interrupt source; here it gates every o_irq_req bit but not the event o_irq output
// R9: Brownout interrupt enable bit
// R10: Serial, timer and external interrupt enables
// R11: Keypad pin enable, one bit per pin
// R12: Reserved bits read zero, ignore writes
// R13: Request equals flag, enable and gate
`ifndef AUX_IRQ_DEFS_SVH
`define AUX_IRQ_DEFS_SVH
`define OFS_AUX_ONE 8'ha2
`define OFS_KEYPAD_EN 8'ha1
`define OFS_IRQ_EN 8'ha8
`define OFS_SLAVE_ADDR 8'ha9
`define OFS_EVT_STATUS 8'hb0
`define OFS_EVT_MASK 8'hb4
`define BIT_KEY_FLAG 7
`define BIT_BO_OFF 6
`define BIT_BO_IRQ 5
`define BIT_LPB 4
`define BIT_SOFT_RST 3
`define BIT_BANK_SEL 0
`define BIT_GATE 7
`define BIT_BO_IRQ_EN 5
`define AUX_WMASK 8'hf9
`define AUX_RMASK 8'hf1
`define IRQEN_WMASK 8'hbf
`define RST_BYTE 8'h00
`define EVT_KEYPAD 0
`define EVT_BROWNOUT 1
`define EVT_SOFT_RST 2
`define EVT_WMASK 8'h07
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- hw/aux_irq_pkg.sv ----
// Types for the aux/irq block
package aux_irq_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_s;
  typedef struct packed {
    logic [5:0] req;
    logic brownout_reset;
    logic detector_power;
    logic rc_osc_on;
  } core_ctl_s;
endpackage

// ---- hw/aux_irq_regs.sv ----
// Aux control, keypad enable and interrupt enable registers on AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "aux_irq_defs.svh"
module aux_irq_regs (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pins and core status
  input wire logic [7:0] i_port0_pins,
  input wire logic i_brownout_flag,
  input wire logic i_power_down,
  input wire logic [4:0] i_src_flags,
  // Core controls
  output logic [5:0] o_irq_req,
  output logic o_chip_reset,
  output logic o_detector_power,
  output logic o_rc_osc_on,
  output logic o_pointer_bank_select,
  output logic o_irq
);
  // Pin inputs through two flops before any use
  logic [7:0] p0_s1_r, p0_s2_r;
  // Pin flops carry no reset; they flush within two cycles anyway
  logic bflag_s1_r, bflag_s2_r, pd_s1_r, pd_s2_r;
  always_ff @(posedge i_core_clk) begin
    p0_s1_r <= i_port0_pins;
    p0_s2_r <= p0_s1_r;
    bflag_s1_r <= i_brownout_flag;
    bflag_s2_r <= bflag_s1_r;
    pd_s1_r <= i_power_down;
    pd_s2_r <= pd_s1_r;
  end

  // Registers
  logic [7:0] aux_r, aux_nxt, kpe_r, kpe_nxt, sad_r, sad_nxt;
  logic [7:0] irqen_r, irqen_nxt;
  logic [7:0] sts_r, sts_nxt, msk_r, msk_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic soft_rst_r, soft_rst_nxt;
  logic awready_r, wready_r, arready_r, chip_rst_r;
  aux_irq_pkg::core_ctl_s ctl_r, ctl_nxt;
  aux_irq_pkg::wr_req_s wr;
  logic do_wr, keypad_hit, bo_irq_evt, bo_act;
  logic [7:0] wbyte;

  // Ready flags registered from the next hold and valid state
  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_arready = arready_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    if (i_awvalid && o_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = i_wdata;
    end
    wr.addr = aw_hold_r ? awaddr_r : i_awaddr;
    wr.data = w_hold_r ? wdata_r : i_wdata;
    wr.strb = i_wstrb;
    do_wr = (aw_hold_nxt && w_hold_nxt) && !bvalid_r && wr.strb[0];
    if (aw_hold_nxt && w_hold_nxt && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
    end
    wbyte = wr.data[7:0];
  end

  always_comb begin
    aux_nxt = aux_r;
    kpe_nxt = kpe_r;
    irqen_nxt = irqen_r;
    sad_nxt = sad_r;
    msk_nxt = msk_r;
    soft_rst_nxt = 1'b0;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && i_bready)
      bvalid_nxt = 1'b0;
    if (aw_hold_r || (i_awvalid && o_awready)) begin
      if ((w_hold_r || (i_wvalid && o_wready)) && !bvalid_r) begin
        bvalid_nxt = 1'b1;
        bresp_nxt = `RESP_OKAY;
        case (wr.addr)
          `OFS_AUX_ONE, `OFS_KEYPAD_EN, `OFS_IRQ_EN, `OFS_SLAVE_ADDR,
          `OFS_EVT_STATUS, `OFS_EVT_MASK: bresp_nxt = `RESP_OKAY;
          default: bresp_nxt = `RESP_SLVERR;
        endcase
      end
    end
    if (do_wr) begin
      case (wr.addr)
        `OFS_AUX_ONE: begin
          // Flag only clears from software; reserved bits stay zero
          aux_nxt = (wbyte & `AUX_WMASK & `AUX_RMASK) |
            (aux_r & ~(`AUX_WMASK & `AUX_RMASK)); // [R12]
          soft_rst_nxt = wbyte[`BIT_SOFT_RST]; // [R6]
        end
        `OFS_KEYPAD_EN: kpe_nxt = wbyte; // [R11]
        `OFS_IRQ_EN: irqen_nxt = wbyte & `IRQEN_WMASK; // [R12]
        `OFS_SLAVE_ADDR: sad_nxt = wbyte;
        `OFS_EVT_MASK: msk_nxt = wbyte & `EVT_WMASK;
        default: ;
      endcase
    end
    // Set wins over a software clear in the same cycle
    keypad_hit = |(~p0_s2_r & kpe_r); // [R1] [R11]
    if (keypad_hit)
      aux_nxt[`BIT_KEY_FLAG] = 1'b1; // [R1]
    // Brownout acts only while detection is on
    bo_act = !aux_r[`BIT_BO_OFF] && bflag_s2_r; // [R2]
    bo_irq_evt = bo_act && aux_r[`BIT_BO_IRQ]; // [R3]
    sts_nxt = sts_r;
    if (do_wr && wr.addr == `OFS_EVT_STATUS)
      sts_nxt = sts_r & ~(wbyte & `EVT_WMASK);
    if (keypad_hit)
      sts_nxt[`EVT_KEYPAD] = 1'b1;
    if (bo_irq_evt)
      sts_nxt[`EVT_BROWNOUT] = 1'b1;
    if (soft_rst_r)
      sts_nxt[`EVT_SOFT_RST] = 1'b1;
    if (i_sys_rst) begin
      aux_nxt = `RST_BYTE;
      kpe_nxt = `RST_BYTE;
      irqen_nxt = `RST_BYTE;
      sad_nxt = `RST_BYTE;
      msk_nxt = `RST_BYTE;
      sts_nxt = `RST_BYTE;
      soft_rst_nxt = 1'b0;
      bvalid_nxt = 1'b0;
      bresp_nxt = `RESP_OKAY;
    end
  end

  // Read channel
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && i_rready)
      rvalid_nxt = 1'b0;
    if (i_arvalid && o_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (i_araddr)
        `OFS_AUX_ONE: rdata_nxt[7:0] = aux_r & `AUX_RMASK; // [R12]
        `OFS_KEYPAD_EN: rdata_nxt[7:0] = kpe_r;
        `OFS_IRQ_EN: rdata_nxt[7:0] = irqen_r & `IRQEN_WMASK; // [R12]
        `OFS_SLAVE_ADDR: rdata_nxt[7:0] = sad_r;
        `OFS_EVT_STATUS: rdata_nxt[7:0] = sts_r;
        `OFS_EVT_MASK: rdata_nxt[7:0] = msk_r;
        default: rresp_nxt = `RESP_SLVERR;
      endcase
    end
    if (i_sys_rst) begin
      rvalid_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = `RESP_OKAY;
    end
  end

  // Core-facing controls, all registered
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      ctl_nxt.req[n] = i_src_flags[n] & irqen_r[n] &
        irqen_r[`BIT_GATE]; // [R10] [R13]
    end
    // Brownout only requests an interrupt in irq mode
    ctl_nxt.req[5] = bo_irq_evt & irqen_r[`BIT_BO_IRQ_EN] &
      irqen_r[`BIT_GATE]; // [R9] [R8]
    ctl_nxt.brownout_reset = bo_act && !aux_r[`BIT_BO_IRQ]; // [R3]
    ctl_nxt.detector_power = !aux_r[`BIT_BO_OFF] &&
      (!aux_r[`BIT_LPB] || pd_s2_r); // [R4]
    ctl_nxt.rc_osc_on = !aux_r[`BIT_BO_OFF] && pd_s2_r; // [R5]
    if (i_sys_rst)
      ctl_nxt = '0;
  end

  always_ff @(posedge i_core_clk) begin
    aw_hold_r <= i_sys_rst ? 1'b0 : aw_hold_nxt;
    w_hold_r <= i_sys_rst ? 1'b0 : w_hold_nxt;
    awaddr_r <= awaddr_nxt;
    wdata_r <= wdata_nxt;
    aux_r <= aux_nxt;
    kpe_r <= kpe_nxt;
    irqen_r <= irqen_nxt;
    sad_r <= sad_nxt;
    sts_r <= sts_nxt;
    msk_r <= msk_nxt;
    soft_rst_r <= soft_rst_nxt;
    bvalid_r <= bvalid_nxt;
    bresp_r <= bresp_nxt;
    rvalid_r <= rvalid_nxt;
    rdata_r <= rdata_nxt;
    rresp_r <= rresp_nxt;
    ctl_r <= ctl_nxt;
    o_irq <= i_sys_rst ? 1'b0 : |(sts_nxt & msk_nxt);
    // Every port leaves from a flop, so no glitch reaches the core
    awready_r <= i_sys_rst ? 1'b1 : !aw_hold_nxt && !bvalid_nxt;
    wready_r <= i_sys_rst ? 1'b1 : !w_hold_nxt && !bvalid_nxt;
    arready_r <= i_sys_rst ? 1'b1 : !rvalid_nxt;
    chip_rst_r <= soft_rst_nxt | ctl_nxt.brownout_reset; // [R6] [R3]
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_irq_req = ctl_r.req;
  // Soft reset is a one-cycle pulse, widened by the chip reset tree
  assign o_chip_reset = chip_rst_r; // [R6] [R3]
  assign o_detector_power = ctl_r.detector_power;
  assign o_rc_osc_on = ctl_r.rc_osc_on;
  assign o_pointer_bank_select = aux_r[`BIT_BANK_SEL]; // [R7]

  // Assertions
  a_gate_blocks_all: assert property (@(posedge i_core_clk) // [R8]
    disable iff (i_sys_rst) !irqen_r[`BIT_GATE] |=> o_irq_req == 6'h00)
    else $error("request passed closed gate");
  a_keypad_sets_flag: assert property (@(posedge i_core_clk) // [R1]
    disable iff (i_sys_rst) keypad_hit |=> aux_r[`BIT_KEY_FLAG])
    else $error("keypad flag not set");
  a_flag_holds: assert property (@(posedge i_core_clk) // [R1]
    disable iff (i_sys_rst) aux_r[`BIT_KEY_FLAG] && !do_wr |=>
    aux_r[`BIT_KEY_FLAG]) else $error("keypad flag lost");
  a_status_keypad: assert property (@(posedge i_core_clk) // [R1]
    disable iff (i_sys_rst) keypad_hit |=> sts_r[`EVT_KEYPAD])
    else $error("keypad status not set");
  a_bo_off_quiet: assert property (@(posedge i_core_clk) // [R2]
    disable iff (i_sys_rst) aux_r[`BIT_BO_OFF] |=> !ctl_r.brownout_reset
    && !ctl_r.req[5]) else $error("brownout acted while off");
  a_bo_off_idle: assert property (@(posedge i_core_clk) // [R2]
    disable iff (i_sys_rst) aux_r[`BIT_BO_OFF] |=> !o_detector_power &&
    !o_rc_osc_on) else $error("detector powered while off");
  a_bo_mode_reset: assert property (@(posedge i_core_clk) // [R3]
    disable iff (i_sys_rst) aux_r[`BIT_BO_IRQ] |=> !ctl_r.brownout_reset)
    else $error("reset in irq mode");
  a_bo_reset_mode: assert property (@(posedge i_core_clk) // [R3]
    disable iff (i_sys_rst) bo_act && !aux_r[`BIT_BO_IRQ] |=> o_chip_reset)
    else $error("no brownout reset");
  a_sleep_power: assert property (@(posedge i_core_clk) // [R4]
    disable iff (i_sys_rst) aux_r[`BIT_LPB] && !pd_s2_r |=>
    !o_detector_power) else $error("detector on in run");
  a_rc_osc_run: assert property (@(posedge i_core_clk) // [R5]
    disable iff (i_sys_rst) !aux_r[`BIT_BO_OFF] && pd_s2_r |=> o_rc_osc_on)
    else $error("rc oscillator off");
  a_soft_reset: assert property (@(posedge i_core_clk) // [R6]
    disable iff (i_sys_rst) do_wr && wr.addr == `OFS_AUX_ONE &&
    wbyte[`BIT_SOFT_RST] |=> o_chip_reset) else $error("no soft reset");
  a_soft_pulse: assert property (@(posedge i_core_clk) // [R6]
    disable iff (i_sys_rst) soft_rst_r |=> !soft_rst_r)
    else $error("soft reset longer than one cycle");
  a_bo_req_path: assert property (@(posedge i_core_clk) // [R9]
    disable iff (i_sys_rst) bo_irq_evt && irqen_r[`BIT_BO_IRQ_EN] &&
    irqen_r[`BIT_GATE] |=> o_irq_req[5]) else $error("brownout irq lost");
  a_reserved_zero: assert property (@(posedge i_core_clk) // [R12]
    disable iff (i_sys_rst) (aux_r[2:1] == 2'b00) && !irqen_r[6])
    else $error("reserved bit set");
  a_req_formed: assert property (@(posedge i_core_clk) // [R13] [R10]
    disable iff (i_sys_rst) 1'b1 |=> o_irq_req[4:0] ==
    ($past(i_src_flags) & $past(irqen_r[4:0]) & {5{$past(irqen_r[7])}}))
    else $error("request mismatch");
  a_irq_level: assert property (@(posedge i_core_clk) // [R13]
    disable iff (i_sys_rst) 1'b1 |=> o_irq == $past(|(sts_nxt & msk_nxt)))
    else $error("irq level mismatch");

  // Covers for the main scenarios
  c_keypad: cover property (@(posedge i_core_clk) keypad_hit);
  c_bo_irq: cover property (@(posedge i_core_clk) ctl_r.req[5]);
  c_bo_reset: cover property (@(posedge i_core_clk) ctl_r.brownout_reset);
  c_soft_rst: cover property (@(posedge i_core_clk) soft_rst_r);
  c_irq: cover property (@(posedge i_core_clk) o_irq);
endmodule

// ---- sim/aux_irq_regs_tb.sv ----
// Self-checking bench for the aux control and irq enable registers
`include "aux_irq_defs.svh"
module aux_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 0;
  logic i_sys_rst = 1;
  logic [7:0] i_awaddr = 0, i_araddr = 0, i_port0_pins = 8'hff;
  logic i_awvalid = 0, i_wvalid = 0, i_arvalid = 0;
  logic [31:0] i_wdata = 0;
  logic i_brownout_flag = 0, i_power_down = 0;
  logic [4:0] i_src_flags = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [31:0] o_rdata, rd_data;
  logic [5:0] o_irq_req;
  logic o_chip_reset, o_detector_power, o_rc_osc_on, o_pointer_bank_select;
  logic o_irq;
  int bad_count = 0, check_count = 0, pulses = 0, k;
  logic [7:0] v, en_v;
  always #5 i_core_clk = ~i_core_clk;
  // Pulses are counted mid-cycle so a one-cycle strobe is never missed
  always @(negedge i_core_clk) if (o_chip_reset === 1'b1) pulses++;
  aux_irq_regs u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hf), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(1'b1), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(1'b1), .i_port0_pins(i_port0_pins),
    .i_brownout_flag(i_brownout_flag), .i_power_down(i_power_down),
    .i_src_flags(i_src_flags), .o_irq_req(o_irq_req),
    .o_chip_reset(o_chip_reset), .o_detector_power(o_detector_power),
    .o_rc_osc_on(o_rc_osc_on),
    .o_pointer_bank_select(o_pointer_bank_select), .o_irq(o_irq));
  function automatic logic [5:0] exp_req(input logic [7:0] e, a,
      input logic [4:0] f, input logic b);
    exp_req = {b & ~a[6] & a[5] & e[5], f & e[4:0]} & {6{e[7]}};
  endfunction
  function automatic logic exp_pwr(input logic off, lpb, pd);
    exp_pwr = ~off & (~lpb | pd);
  endfunction
  task automatic chk_val(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, d, output logic [1:0] r);
    logic ah, wh, bv;
    int n;
    ah = 0; wh = 0; bv = 0; n = 0;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1;
    i_wvalid <= 1;
    while (!(ah && wh) && n < 40) begin
      @(negedge i_core_clk);
      ah |= i_awvalid & o_awready;
      wh |= i_wvalid & o_wready;
      @(posedge i_core_clk);
      if (ah) i_awvalid <= 0;
      if (wh) i_wvalid <= 0;
      n++;
    end
    while (!bv && n < 40) begin
      @(negedge i_core_clk);
      bv = o_bvalid;
      r = o_bresp;
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 40) bad_count++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic ah, rv;
    int n;
    ah = 0; rv = 0; n = 0;
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    while (!ah && n < 40) begin
      @(negedge i_core_clk);
      ah = o_arready;
      @(posedge i_core_clk);
      if (ah) i_arvalid <= 0;
      n++;
    end
    while (!rv && n < 40) begin
      @(negedge i_core_clk);
      rv = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 40) bad_count++;
  endtask
  task automatic wr_ok(input logic [7:0] a, d);
    wr(a, d, rsp);
    chk_resp("bresp", `RESP_OKAY, rsp);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_data, rsp);
    chk_resp("rresp", `RESP_OKAY, rsp);
    chk_val("rdata", e, rd_data);
  endtask
  task automatic settle;
    repeat (6) @(posedge i_core_clk);
  endtask
  task automatic test_done;
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'hdc10));
    repeat (4) @(posedge i_core_clk);
    i_sys_rst <= 0;
    rd_chk(`OFS_AUX_ONE, 0);
    rd_chk(`OFS_IRQ_EN, 0);
    // Irq mode kept on here so a random brownout never resets the chip
    for (k = 0; k < 14; k++) begin
      v = ($urandom & 8'h57) | 8'h20;
      en_v = (k == 0) ? 8'h7f : (k == 1) ? 8'hff : 8'($urandom);
      wr_ok(`OFS_AUX_ONE, v);
      wr_ok(`OFS_IRQ_EN, en_v);
      i_src_flags <= (k < 2) ? 5'h1f : 5'($urandom);
      i_brownout_flag <= (k < 2) ? 1'b1 : 1'($urandom);
      i_power_down <= 1'($urandom);
      settle();
      rd_chk(`OFS_AUX_ONE, v & `AUX_RMASK);
      rd_chk(`OFS_IRQ_EN, en_v & 8'hbf);
      chk_val("bank", v[0], o_pointer_bank_select);
      chk_val("req", exp_req(en_v, v, i_src_flags, i_brownout_flag),
        o_irq_req);
      chk_val("power", exp_pwr(v[6], v[4], i_power_down),
        o_detector_power);
      chk_val("rcosc", ~v[6] & i_power_down, o_rc_osc_on);
      chk_val("reset", 0, o_chip_reset);
    end
    i_brownout_flag <= 1;
    wr_ok(`OFS_AUX_ONE, 8'h40);
    settle();
    chk_val("reset", 0, o_chip_reset);
    wr_ok(`OFS_AUX_ONE, 8'h00);
    settle();
    chk_val("reset", 1, o_chip_reset);
    i_brownout_flag <= 0;
    i_power_down <= 0;
    settle();
    wr_ok(`OFS_AUX_ONE, 8'h00);
    k = $urandom_range(7, 0);
    wr_ok(`OFS_KEYPAD_EN, 8'h01 << k);
    i_port0_pins <= ~(8'h01 << ((k + 1) % 8));
    settle();
    rd_chk(`OFS_AUX_ONE, 0);
    i_port0_pins <= ~(8'h01 << k);
    settle();
    i_port0_pins <= 8'hff;
    settle();
    rd_chk(`OFS_AUX_ONE, 8'h80);
    chk_val("irq", 0, o_irq);
    wr_ok(`OFS_EVT_MASK, 8'h01);
    settle();
    chk_val("irq", 1, o_irq);
    wr_ok(`OFS_EVT_STATUS, 8'h01);
    settle();
    chk_val("irq", 0, o_irq);
    wr_ok(`OFS_AUX_ONE, 8'h00);
    rd_chk(`OFS_AUX_ONE, 0);
    wr(8'h10, 8'h55, rsp);
    chk_resp("bresp", `RESP_SLVERR, rsp);
    rd(8'h10, rd_data, rsp);
    chk_resp("rresp", `RESP_SLVERR, rsp);
    chk_val("rdata", 0, rd_data);
    v = 8'($urandom);
    wr_ok(`OFS_SLAVE_ADDR, v);
    rd_chk(`OFS_SLAVE_ADDR, v);
    rd_chk(`OFS_EVT_MASK, 8'h01);
    // Soft reset last, since it may clear everything set above
    pulses = 0;
    wr_ok(`OFS_AUX_ONE, 8'h08);
    settle();
    chk_val("pulses", 1, pulses);
    rd_chk(`OFS_AUX_ONE, 0);
    test_done();
  end
endmodule
